// ==== rtl/ssr_receiver.sv ====
// ssr_receiver: synchronous slave receive path with avalon-mm register access.
// assumes CK_IN and DT_IN are asynchronous pins; the shift clock is sampled by MCLK.
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module ssr_receiver
	import ssr_pkg::*;
(
	// clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// avalon-mm slave
	input wire logic [5:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// serial pins
	input wire logic CK_IN,
	input wire logic DT_IN,
	// core side
	output logic WAKE_REQ,
	output logic VECTOR_REQ,
	output logic IRQ
);
	typedef struct packed {
		logic [1:0] ck_sync;
		logic [1:0] dt_sync;
		logic ck_prev;
		logic [WORD_W-1:0] shift;
		logic [3:0] bit_cnt;
		logic [FIFO_DEPTH-1:0][WORD_W-1:0] fifo;
		logic [1:0] count;
		logic overrun_error_flag;
		logic [7:0] tx_stat;
		logic [7:0] rx_ctrl;
		logic [7:0] baud;
		logic [7:0] tx_data;
		logic [7:0] int_ctrl;
		logic [7:0] peripheral_irq_enable_1;
		logic [7:0] ck_sel;
		logic [7:0] dt_sel;
		logic [EV_W-1:0] ev_stat;
		logic [EV_W-1:0] ev_en;
		logic ack;
		logic [31:0] rdata;
	} ssr_state_s;

	ssr_state_s s_q, s_d;

	logic serial_port_enable, ninth, active_edge, word_done, rd_data, push, wr, rd;
	logic [7:0] wbyte, rd_byte;
	logic [3:0] word_len;

	assign serial_port_enable = s_q.rx_ctrl[RX_SERIAL_PORT_ENABLE];
	assign ninth = s_q.rx_ctrl[RX_NINTH_EN];
	assign word_len = ninth ? 4'h9 : 4'h8;
	// only the second synchroniser stage and its delayed copy feed the edge detector
	assign active_edge = s_q.baud[BD_CLOCK_POLARITY_SELECT] ?
		(s_q.ck_prev & ~s_q.ck_sync[1]) : (~s_q.ck_prev & s_q.ck_sync[1]);
	// reception is gated by port enable only: continuous receive treated as on, single ignored
	assign word_done = serial_port_enable & active_edge &
		(s_q.bit_cnt == word_len - 4'h1);
	// writes and the buffer pop land on the edge where waitrequest is low
	assign wr = AVS_WRITE & s_q.ack;
	assign rd = AVS_READ & ~s_q.ack;
	assign wbyte = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : 8'h00;
	assign rd_data = AVS_READ & s_q.ack & (AVS_ADDRESS == OFF_RX_DATA);
	assign push = word_done & (s_q.count != 2'(FIFO_DEPTH));

	always_comb begin
		logic [WORD_W-1:0] shifted;
		logic [7:0] rx_rd;
		shifted = '0;
		rx_rd = '0;
		s_d = s_q;
		rd_byte = 8'h00;
		s_d.ck_sync = {s_q.ck_sync[0], CK_IN};
		s_d.dt_sync = {s_q.dt_sync[0], DT_IN};
		s_d.ck_prev = s_q.ck_sync[1];
		s_d.ack = (AVS_READ | AVS_WRITE) & ~s_q.ack;

		// shifter: lsb first, word lands right-aligned at bit 0 for either length
		if (serial_port_enable && active_edge) begin
			shifted = {s_q.dt_sync[1], s_q.shift[WORD_W-1:1]};
			if (word_done) begin
				s_d.bit_cnt = 4'h0;
				s_d.shift = '0;
			end else begin
				s_d.bit_cnt = s_q.bit_cnt + 4'h1;
				s_d.shift = shifted;
			end
		end

		// pop on read of receive data
		if (rd_data && s_q.count != 2'h0) begin
			s_d.fifo[0] = s_q.fifo[1];
			s_d.count = s_q.count - 2'h1;
		end
		if (word_done) begin
			shifted = {s_q.dt_sync[1], s_q.shift[WORD_W-1:1]};
			if (!ninth) begin
				shifted = {1'b0, shifted[WORD_W-1:1]};
			end
			if (push) begin
				s_d.fifo[s_d.count[0]] = shifted;
				s_d.count = s_d.count + 2'h1;
			end else if (!(rd_data && s_q.count != 2'h0)) begin
				s_d.overrun_error_flag = 1'b1;
			end else begin
				s_d.fifo[1] = shifted;
				s_d.count = 2'h2;
			end
		end

		// register reads
		rx_rd = s_q.rx_ctrl & RX_STAT_WMASK;
		rx_rd[RX_OVERRUN_ERROR_FLAG] = s_q.overrun_error_flag;
		rx_rd[RX_NINTH_VAL] = s_q.fifo[0][8] & ninth;
		unique case (AVS_ADDRESS)
			OFF_TX_STAT: rd_byte = (s_q.tx_stat & TX_STAT_WMASK) | TX_STAT_RST;
			OFF_RX_STAT: rd_byte = rx_rd;
			OFF_BAUD: rd_byte = (s_q.baud & BAUD_WMASK) | {1'b0, s_q.bit_cnt == 4'h0, 6'h00};
			OFF_RX_DATA: rd_byte = s_q.fifo[0][7:0];
			OFF_INT_CTRL: rd_byte = s_q.int_ctrl;
			OFF_PERIPHERAL_IRQ_ENABLE_1: rd_byte = s_q.peripheral_irq_enable_1;
			OFF_PERIPHERAL_IRQ_FLAG_1: rd_byte = {2'b00, s_q.count != 2'h0, 5'h00};
			OFF_CK_SEL: rd_byte = s_q.ck_sel;
			OFF_DT_SEL: rd_byte = s_q.dt_sel;
			OFF_EV_STAT: rd_byte = {6'h00, s_q.ev_stat};
			OFF_EV_EN: rd_byte = {6'h00, s_q.ev_en};
			default: rd_byte = 8'h00;
		endcase
		if (rd) begin
			s_d.rdata = {24'h0, rd_byte};
		end

		// register writes
		if (wr && AVS_BYTEENABLE[0]) begin
			unique case (AVS_ADDRESS)
				OFF_TX_STAT: s_d.tx_stat = wbyte & TX_STAT_WMASK;
				OFF_RX_STAT: s_d.rx_ctrl = wbyte & RX_STAT_WMASK;
				OFF_BAUD: s_d.baud = wbyte & BAUD_WMASK;
				OFF_TX_DATA: s_d.tx_data = wbyte;
				OFF_INT_CTRL: s_d.int_ctrl = wbyte & INT_WMASK;
				OFF_PERIPHERAL_IRQ_ENABLE_1: s_d.peripheral_irq_enable_1 = wbyte & PERIPHERAL_IRQ_ENABLE_1_WMASK;
				OFF_CK_SEL: s_d.ck_sel = wbyte & PPS_WMASK;
				OFF_DT_SEL: s_d.dt_sel = wbyte & PPS_WMASK;
				OFF_EV_CLR: s_d.ev_stat = s_q.ev_stat & ~wbyte[EV_W-1:0];
				OFF_EV_EN: s_d.ev_en = wbyte[EV_W-1:0];
				default: ;
			endcase
		end

		// overrun clears when continuous receive or port enable drops
		if (!s_d.rx_ctrl[RX_CONTINUOUS_RECEIVE_ENABLE]) begin
			s_d.overrun_error_flag = 1'b0;
		end
		// port disabled: shifter, bit count, buffer and overrun flag cleared; event status kept
		if (!s_d.rx_ctrl[RX_SERIAL_PORT_ENABLE]) begin
			s_d.overrun_error_flag = 1'b0;
			s_d.shift = '0;
			s_d.bit_cnt = 4'h0;
			s_d.count = 2'h0;
			s_d.fifo = '0;
		end

		// events set after clear so a same-cycle event wins
		if (word_done) begin
			s_d.ev_stat[EV_WORD] = 1'b1;
		end
		if (word_done && !push && !(rd_data && s_q.count != 2'h0)) begin
			s_d.ev_stat[EV_OVR] = 1'b1;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			s_q <= '0;
			s_q.tx_stat <= TX_STAT_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// irq path from receive-complete, wake independent of global enable
	logic rc_pend;
	assign rc_pend = (s_q.count != 2'h0) & s_q.peripheral_irq_enable_1[PI_RC];
	assign WAKE_REQ = rc_pend & s_q.int_ctrl[IC_PERIPHERAL_INTERRUPT_ENABLE];
	assign VECTOR_REQ = rc_pend & s_q.int_ctrl[IC_PERIPHERAL_INTERRUPT_ENABLE] & s_q.int_ctrl[IC_GIE];
	assign IRQ = |(s_q.ev_stat & s_q.ev_en);
	assign AVS_READDATA = s_q.rdata;
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~s_q.ack;
endmodule

// ==== shared/ssr_pkg.sv ====
// ssr_pkg: register map, field positions and reset values of the slave serial receiver.
// assumes a 32-bit avalon-mm slave with word-aligned registers.
package ssr_pkg;
	// register byte offsets
	localparam logic [5:0] OFF_TX_STAT = 6'h00;
	localparam logic [5:0] OFF_RX_STAT = 6'h04;
	localparam logic [5:0] OFF_BAUD = 6'h08;
	localparam logic [5:0] OFF_RX_DATA = 6'h0c;
	localparam logic [5:0] OFF_TX_DATA = 6'h10;
	localparam logic [5:0] OFF_INT_CTRL = 6'h14;
	localparam logic [5:0] OFF_PERIPHERAL_IRQ_ENABLE_1 = 6'h18;
	localparam logic [5:0] OFF_PERIPHERAL_IRQ_FLAG_1 = 6'h1c;
	localparam logic [5:0] OFF_CK_SEL = 6'h20;
	localparam logic [5:0] OFF_DT_SEL = 6'h24;
	localparam logic [5:0] OFF_EV_STAT = 6'h28;
	localparam logic [5:0] OFF_EV_CLR = 6'h2c;
	localparam logic [5:0] OFF_EV_EN = 6'h30;
	// transmit_status_control fields
	localparam int TX_CLK_SRC = 7;
	localparam int TX_NINTH_EN = 6;
	localparam int TX_EN = 5;
	localparam int TX_SYNC = 4;
	localparam int TX_TRMT = 1;
	// receive_status_control fields
	localparam int RX_SERIAL_PORT_ENABLE = 7;
	localparam int RX_NINTH_EN = 6;
	localparam int RX_SINGLE_RECEIVE_ENABLE = 5;
	localparam int RX_CONTINUOUS_RECEIVE_ENABLE = 4;
	localparam int RX_OVERRUN_ERROR_FLAG = 1;
	localparam int RX_NINTH_VAL = 0;
	// baud_control fields
	localparam int BD_IDLE = 6;
	localparam int BD_CLOCK_POLARITY_SELECT = 4;
	// interrupt_control and peripheral irq fields
	localparam int IC_GIE = 7;
	localparam int IC_PERIPHERAL_INTERRUPT_ENABLE = 6;
	localparam int PI_RC = 5;
	// event status bits
	localparam int EV_WORD = 0;
	localparam int EV_OVR = 1;
	localparam int EV_W = 2;
	// writable masks and reset values
	localparam logic [7:0] TX_STAT_WMASK = 8'hf0;
	localparam logic [7:0] RX_STAT_WMASK = 8'hf0;
	localparam logic [7:0] BAUD_WMASK = 8'h10;
	localparam logic [7:0] INT_WMASK = 8'hc0;
	localparam logic [7:0] PERIPHERAL_IRQ_ENABLE_1_WMASK = 8'h20;
	localparam logic [7:0] PPS_WMASK = 8'h1f;
	localparam logic [7:0] TX_STAT_RST = 8'h02;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam int FIFO_DEPTH = 2;
	localparam int WORD_W = 9;
endpackage

// ==== tb/ssr_master_model.sv ====
// ssr_master_model: external synchronous master driving shift clock and data.
// assumes the slave samples data on the edge chosen by its polarity select.
`timescale 1ns/1ps
module ssr_master_model(
	// link pins
	output logic ck,
	output logic dt
);
	initial begin
		ck = 0;
		dt = 0;
	end
	// 800 ns period; clock stands still between frames
	task automatic send(input logic [8:0] w, input int n, input bit inv);
		ck = inv;
		#400;
		for (int i = 0; i < n; i++) begin
			dt = w[i];
			#400 ck = !inv;
			#400 ck = inv;
		end
		dt = !dt;
	endtask
endmodule

// ==== tb/ssr_monitor.sv ====
// ssr_monitor: port-level properties of the slave serial receiver.
// assumes it is bound to ssr_receiver and sees only its ports.
`timescale 1ns/1ps
module ssr_monitor(
	// bus and clock
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	// core side
	input wire logic WAKE_REQ,
	input wire logic VECTOR_REQ,
	input wire logic IRQ
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	property p_vec; VECTOR_REQ |-> WAKE_REQ; endproperty
	a_vec: assert property (p_vec) else $error("vector without wake");
	property p_hi0; AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0; endproperty
	a_hi0: assert property (p_hi0) else $error("upper read bits set");
	property p_one; AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
	a_one: assert property (p_one) else $error("more than one wait cycle");
	property p_first; $rose(AVS_READ) || $rose(AVS_WRITE) |-> AVS_WAITREQUEST; endproperty
	a_first: assert property (p_first) else $error("no wait in first cycle");
	property p_hold; !AVS_READ |=> $stable(AVS_READDATA); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_wake; WAKE_REQ && !AVS_READ && !AVS_WRITE |=> WAKE_REQ; endproperty
	a_wake: assert property (p_wake) else $error("wake dropped alone");
	property p_irq; IRQ && !AVS_WRITE |=> IRQ; endproperty
	a_irq: assert property (p_irq) else $error("event not sticky");
	property p_idle; !AVS_READ && !AVS_WRITE |-> !AVS_WAITREQUEST; endproperty
	a_idle: assert property (p_idle) else $error("wait without request");
endmodule

// ==== tb/testbench.sv ====
// testbench: register-level tests of the slave serial receiver.
// assumes ssr_pkg offsets and the one-wait-cycle avalon slave.
`timescale 1ns/1ps
module testbench;
	import ssr_pkg::*;
	logic MCLK, RST_N, AVS_READ, AVS_WRITE, CK_IN, DT_IN;
	logic [5:0] AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA;
	logic [3:0] AVS_BYTEENABLE;
	logic AVS_WAITREQUEST, WAKE_REQ, VECTOR_REQ, IRQ;
	int n_errors, n_compared, cyc;
	ssr_receiver dut(.MCLK, .RST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
		.AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .CK_IN, .DT_IN, .WAKE_REQ,
		.VECTOR_REQ, .IRQ);
	ssr_master_model m(.ck(CK_IN), .dt(DT_IN));
	initial begin
		MCLK = 0;
		forever #50 MCLK = !MCLK;
	end
	task automatic summarize;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	// called just after a rising edge; request held until waitrequest is sampled low
	task automatic bus(input bit w, input logic [5:0] a, input logic [7:0] d,
		output logic [7:0] q);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= {24'h0, d};
		AVS_BYTEENABLE <= 4'h1;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		@(posedge MCLK);
		while (AVS_WAITREQUEST !== 1'b0) @(posedge MCLK);
		q = AVS_READDATA[7:0];
		AVS_READ <= 0;
		AVS_WRITE <= 0;
		// one idle edge so a following call never re-raises in this time step
		@(posedge MCLK);
	endtask
	task automatic rc(input logic [5:0] a, input logic [7:0] e, input string n);
		logic [7:0] q;
		bus(0, a, 8'h00, q);
		chk(n, {24'h0, q}, {24'h0, e});
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1, a, d, q);
	endtask
	task automatic rx(input logic [8:0] w, input int n, input bit inv);
		m.send(w, n, inv);
		repeat (4) @(posedge MCLK);
	endtask
	initial begin
		RST_N = 0;
		AVS_READ = 0;
		AVS_WRITE = 0;
		AVS_ADDRESS = 0;
		AVS_WRITEDATA = 0;
		AVS_BYTEENABLE = 0;
		repeat (2) @(posedge MCLK);
		RST_N <= 1;
		@(posedge MCLK);
		rc(OFF_TX_STAT, TX_STAT_RST, "tx_stat");
		rc(OFF_RX_STAT, 8'h00, "rx_stat");
		rc(6'h3c, 8'h00, "unmapped");
		$display("reset test done");
		wr(OFF_TX_STAT, 8'h10);
		wr(OFF_EV_EN, 8'h03);
		wr(OFF_PERIPHERAL_IRQ_ENABLE_1, 8'h20);
		wr(OFF_INT_CTRL, 8'h40);
		wr(OFF_RX_STAT, 8'h90);
		rx(9'h0a5, 8, 0);
		chk("wake", WAKE_REQ, 1);
		chk("vector", VECTOR_REQ, 0);
		chk("irq", IRQ, 1);
		rc(OFF_PERIPHERAL_IRQ_FLAG_1, 8'h20, "peripheral_irq_flag_1");
		rc(OFF_RX_DATA, 8'ha5, "rx_data");
		chk("wake", WAKE_REQ, 0);
		$display("single word test done");
		wr(OFF_INT_CTRL, 8'hc0);
		rx(9'h03c, 8, 0);
		rx(9'h0c3, 8, 0);
		rx(9'h05a, 8, 0);
		chk("vector", VECTOR_REQ, 1);
		rc(OFF_EV_STAT, 8'h03, "ev_stat");
		rc(OFF_RX_STAT, 8'h92, "rx_stat");
		rc(OFF_RX_DATA, 8'h3c, "rx_data");
		wr(OFF_EV_CLR, 8'h03);
		chk("irq", IRQ, 0);
		wr(OFF_RX_STAT, 8'h80);
		rc(OFF_RX_STAT, 8'h80, "rx_stat");
		wr(OFF_RX_STAT, 8'h00);
		rc(OFF_PERIPHERAL_IRQ_FLAG_1, 8'h00, "peripheral_irq_flag_1");
		$display("overrun test done");
		wr(OFF_BAUD, 8'h10);
		wr(OFF_RX_STAT, 8'he0);
		rx(9'h1a5, 9, 1);
		rc(OFF_RX_STAT, 8'he1, "rx_stat");
		rc(OFF_RX_DATA, 8'ha5, "rx_data");
		$display("nine bit test done");
		summarize();
	end
endmodule
bind ssr_receiver ssr_monitor mon(.MCLK, .RST_N, .AVS_READ, .AVS_WRITE, .AVS_READDATA,
	.AVS_WAITREQUEST, .WAKE_REQ, .VECTOR_REQ, .IRQ);
